// [rtl/hfs_pkg.sv]
// package: constants and types for the hex float single precision datapath
package hfs_pkg;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned EXP_W = 7;
	localparam int unsigned MANT_W = 24;
	localparam int unsigned SIGN_POS = 15;
	localparam int unsigned EXP_MSB = 14;
	localparam int unsigned EXP_LSB = 8;
	localparam int unsigned MHI_W = 8;
	localparam int unsigned DIGIT_W = 4;
	localparam logic [6:0] EXP_BIAS = 7'h40;
	localparam logic [6:0] EXP_ZERO = 7'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam int unsigned MUL_STEPS = 24;
	localparam int unsigned DIV_STEPS = 28;
	localparam int unsigned NORM_MAX = 6;
	localparam logic [4:0] CNT_RST = 5'h00;

	typedef enum logic [1:0] {
		HFS_OP_ADD = 2'h0,
		HFS_OP_SUB = 2'h1,
		HFS_OP_MUL = 2'h2,
		HFS_OP_DIV = 2'h3
	} hfs_op_t;

	typedef enum logic [5:0] {
		HFS_IDLE = 6'h01,
		HFS_ALIGN = 6'h02,
		HFS_ITER = 6'h04,
		HFS_CARRY = 6'h08,
		HFS_NORM = 6'h10,
		HFS_DONE = 6'h20
	} hfs_state_t;
endpackage

// [rtl/hfs_cmp.sv]
// magnitude comparator for two normalised single precision operands
`timescale 1ns/100ps
module hfs_cmp
(
	input wire logic [6:0] a_exp,
	input wire logic [23:0] a_mant,
	input wire logic [6:0] b_exp,
	input wire logic [23:0] b_mant,
	output logic a_gt,
	output logic a_eq
);
	// exponents decide first, mantissas only break a tie
	always_comb
	begin
		if (a_exp != b_exp)
		begin
			a_gt = (a_exp > b_exp);
			a_eq = 1'b0;
		end
		else
		begin
			a_gt = (a_mant > b_mant);
			a_eq = (a_mant == b_mant);
		end
	end
endmodule // hfs_cmp

// [rtl/hfs_datapath.sv]
// top: sequential hex float single precision add, subtract, multiply, divide
`timescale 1ns/100ps
module hfs_datapath
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire logic [1:0] op,
	input wire logic [15:0] a_hi,
	input wire logic [15:0] a_lo,
	input wire logic [15:0] b_hi,
	input wire logic [15:0] b_lo,
	output logic busy,
	output logic done,
	output logic [15:0] r_hi,
	output logic [15:0] r_lo,
	output logic exp_ovf,
	output logic exp_unf,
	output logic div_zero
);
	// ----------------------------------------------------------------
	// field helpers
	// ----------------------------------------------------------------
	function automatic logic [6:0] f_exp(input logic [15:0] hi);
		f_exp = hi[hfs_pkg::EXP_MSB:hfs_pkg::EXP_LSB];
	endfunction

	function automatic logic [23:0] f_mant(input logic [15:0] hi, input logic [15:0] lo);
		f_mant = {hi[7:0], lo};
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	hfs_pkg::hfs_state_t state_reg;
	hfs_pkg::hfs_op_t op_reg;
	logic sign_reg;
	logic [8:0] exp_reg; // signed-ish working exponent, bias kept, 2 guard bits
	logic [27:0] acc_reg; // one guard digit above the 24-bit mantissa
	logic [23:0] a_m_reg;
	logic [23:0] b_m_reg;
	logic [4:0] cnt_reg;
	logic [47:0] prod_reg;
	logic sa;
	logic sb;
	logic [6:0] ea;
	logic [6:0] eb;
	logic [23:0] ma;
	logic [23:0] mb;
	logic a_gt;
	logic a_eq;
	logic sb_eff;
	logic [6:0] ediff;
	logic [27:0] small_sh;

	assign sa = a_hi[hfs_pkg::SIGN_POS];
	assign sb = b_hi[hfs_pkg::SIGN_POS];
	assign ea = f_exp(a_hi);
	assign eb = f_exp(b_hi);
	assign ma = f_mant(a_hi, a_lo);
	assign mb = f_mant(b_hi, b_lo);
	assign sb_eff = sb ^ (op == 2'(hfs_pkg::HFS_OP_SUB));

	hfs_cmp u_cmp
	(
		.a_exp(ea),
		.a_mant(ma),
		.b_exp(eb),
		.b_mant(mb),
		.a_gt(a_gt),
		.a_eq(a_eq)
	);

	// alignment shift of the smaller operand, dropped digits lost
	always_comb
	begin
		if (a_gt || a_eq)
			ediff = ea - eb;
		else
			ediff = eb - ea;
		if (ediff > 7'd6)
			small_sh = 28'h0000000;
		else if (a_gt || a_eq)
			small_sh = {4'h0, mb} >> (ediff * 3'(hfs_pkg::DIGIT_W));
		else
			small_sh = {4'h0, ma} >> (ediff * 3'(hfs_pkg::DIGIT_W));
	end

	// ----------------------------------------------------------------
	// control sequence
	// ----------------------------------------------------------------
	// one-hot sequencer; divide keeps a remainder in the low 28 bits of prod_reg
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= hfs_pkg::HFS_IDLE;
			op_reg <= hfs_pkg::HFS_OP_ADD;
			sign_reg <= 1'b0;
			exp_reg <= 9'h000;
			acc_reg <= 28'h0000000;
			a_m_reg <= 24'h000000;
			b_m_reg <= 24'h000000;
			cnt_reg <= hfs_pkg::CNT_RST;
			prod_reg <= 48'h000000000000;
			div_zero <= 1'b0;
		end
		else
		begin
			case (state_reg)
				hfs_pkg::HFS_IDLE:
				begin
					if (start)
					begin
						op_reg <= hfs_pkg::hfs_op_t'(op);
						a_m_reg <= ma;
						b_m_reg <= mb;
						cnt_reg <= hfs_pkg::CNT_RST;
						div_zero <= 1'b0;
						state_reg <= hfs_pkg::HFS_ALIGN;
						if (op[1] == 1'b0)
						begin
							// larger magnitude sets sign and exponent
							if (a_gt || a_eq)
							begin
								sign_reg <= sa;
								exp_reg <= {2'b00, ea};
								acc_reg <= (sa == sb_eff) ? ({4'h0, ma} + small_sh)
									: ({4'h0, ma} - small_sh);
							end
							else
							begin
								sign_reg <= sb_eff;
								exp_reg <= {2'b00, eb};
								acc_reg <= (sa == sb_eff) ? ({4'h0, mb} + small_sh)
									: ({4'h0, mb} - small_sh);
							end
						end
						else if (op == 2'(hfs_pkg::HFS_OP_MUL))
						begin
							sign_reg <= sa ^ sb;
							exp_reg <= {2'b00, ea} + {2'b00, eb} - {2'b00, hfs_pkg::EXP_BIAS};
							prod_reg <= 48'h000000000000;
						end
						else
						begin
							sign_reg <= sa ^ sb;
							exp_reg <= {2'b00, ea} - {2'b00, eb} + {2'b00, hfs_pkg::EXP_BIAS};
							prod_reg <= {24'h000000, ma};
							div_zero <= (mb == 24'h000000);
						end
					end
				end
				hfs_pkg::HFS_ALIGN:
				begin
					state_reg <= op_reg[1] ? hfs_pkg::HFS_ITER : hfs_pkg::HFS_CARRY;
				end
				hfs_pkg::HFS_ITER:
				begin
					cnt_reg <= cnt_reg + 5'h01;
					if (op_reg == hfs_pkg::HFS_OP_MUL)
					begin
						// shift-add, one multiplier bit per cycle; sum is 49 bits so carry survives
						prod_reg <= 48'(({1'b0, prod_reg} + (b_m_reg[cnt_reg]
							? {1'b0, a_m_reg, 24'h000000} : 49'h0000000000000)) >> 1);
						if (cnt_reg == 5'(hfs_pkg::MUL_STEPS - 1))
						begin
							state_reg <= hfs_pkg::HFS_CARRY;
							acc_reg <= 28'h0000000;
						end
					end
					else
					begin
						// restoring division against eight times the divisor: quotient of two
						// normalised mantissas is below 16, so four integer bits come first
						if (prod_reg[27:0] >= {1'b0, b_m_reg, 3'h0})
						begin
							prod_reg[27:0] <= (prod_reg[27:0] - {1'b0, b_m_reg, 3'h0}) << 1;
							acc_reg <= {acc_reg[26:0], 1'b1};
						end
						else
						begin
							prod_reg[27:0] <= prod_reg[27:0] << 1;
							acc_reg <= {acc_reg[26:0], 1'b0};
						end
						if (cnt_reg == 5'(hfs_pkg::DIV_STEPS - 1))
							state_reg <= hfs_pkg::HFS_CARRY;
					end
				end
				hfs_pkg::HFS_CARRY:
				begin
					if (op_reg == hfs_pkg::HFS_OP_MUL && cnt_reg != hfs_pkg::CNT_RST)
					begin
						acc_reg <= {4'h0, prod_reg[47:24]};
						cnt_reg <= hfs_pkg::CNT_RST;
					end
					else
					begin
						if (acc_reg[27:24] != 4'h0)
						begin
							// truncate the digit that falls off
							acc_reg <= acc_reg >> hfs_pkg::DIGIT_W;
							exp_reg <= exp_reg + 9'h001;
						end
						state_reg <= hfs_pkg::HFS_NORM;
					end
				end
				hfs_pkg::HFS_NORM:
				begin
					if (acc_reg[23:0] == 24'h000000)
						state_reg <= hfs_pkg::HFS_DONE;
					else if (acc_reg[23:20] == 4'h0)
					begin
						acc_reg <= acc_reg << hfs_pkg::DIGIT_W;
						exp_reg <= exp_reg - 9'h001;
					end
					else
						state_reg <= hfs_pkg::HFS_DONE;
				end
				hfs_pkg::HFS_DONE:
				begin
					state_reg <= hfs_pkg::HFS_IDLE;
				end
				default:
				begin
					state_reg <= hfs_pkg::HFS_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// result packing
	// ----------------------------------------------------------------
	// exponent range is checked on the 9-bit working value; out of range clamps to zero
	logic res_zero;
	logic res_ovf;
	logic res_unf;
	assign res_zero = (acc_reg[23:0] == 24'h000000) || div_zero;
	assign res_ovf = !exp_reg[8] && exp_reg[7] && !res_zero;
	assign res_unf = exp_reg[8] && !res_zero;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			r_hi <= hfs_pkg::WORD_RST;
			r_lo <= hfs_pkg::WORD_RST;
			done <= 1'b0;
			busy <= 1'b0;
			exp_ovf <= 1'b0;
			exp_unf <= 1'b0;
		end
		else
		begin
			done <= (state_reg == hfs_pkg::HFS_DONE);
			busy <= (state_reg != hfs_pkg::HFS_IDLE) || start;
			if (state_reg == hfs_pkg::HFS_DONE)
			begin
				exp_ovf <= res_ovf;
				exp_unf <= res_unf;
				if (res_zero || res_unf || res_ovf)
				begin
					r_hi <= hfs_pkg::WORD_RST;
					r_lo <= hfs_pkg::WORD_RST;
				end
				else
				begin
					r_hi <= {sign_reg, exp_reg[6:0], acc_reg[23:16]};
					r_lo <= acc_reg[15:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_zero_canon: assert property (@(posedge mclk) disable iff (rst)
		done && r_lo == 16'h0000 && r_hi[7:0] == 8'h00 |-> r_hi == 16'h0000)
		else $error("zero result not canonical");
	a_norm_digit: assert property (@(posedge mclk) disable iff (rst)
		done && r_hi != 16'h0000 |-> r_hi[7:4] != 4'h0)
		else $error("result not normalised");
	a_done_after: assert property (@(posedge mclk) disable iff (rst)
		state_reg == hfs_pkg::HFS_DONE |=> done)
		else $error("done missing");
	a_carry_bump: assert property (@(posedge mclk) disable iff (rst)
		state_reg == hfs_pkg::HFS_CARRY && !(op_reg == hfs_pkg::HFS_OP_MUL
		&& cnt_reg != hfs_pkg::CNT_RST) && acc_reg[27:24] != 4'h0
		|=> exp_reg == $past(exp_reg) + 9'h001)
		else $error("carry did not raise exponent");
	a_norm_step: assert property (@(posedge mclk) disable iff (rst)
		state_reg == hfs_pkg::HFS_NORM && acc_reg[23:0] != 24'h000000
		&& acc_reg[23:20] == 4'h0 |=> exp_reg == $past(exp_reg) - 9'h001
		&& acc_reg[23:4] == $past(acc_reg[19:0]))
		else $error("normalise step wrong");
	a_add_latency: assert property (@(posedge mclk) disable iff (rst)
		state_reg == hfs_pkg::HFS_IDLE && start && op[1] == 1'b0
		|-> ##[4:12] done)
		else $error("add did not finish in time");
endmodule // hfs_datapath

// [sim/hfs_datapath_tb_top.sv]
// self-checking bench for the hex float single precision datapath
`timescale 1ns/100ps
module hfs_datapath_tb_top;
	typedef struct packed {logic [1:0] op; logic [31:0] a; logic [31:0] b;
		logic [31:0] r; logic [2:0] flg;} hfs_row_t;
	logic mclk;
	logic rst;
	logic start;
	logic [1:0] op;
	logic [15:0] a_hi, a_lo, b_hi, b_lo, r_hi, r_lo;
	logic busy, done, exp_ovf, exp_unf, div_zero;
	int mismatches, comparisons, cycles, n;
	// -----------------------------------------------------------------
	// ordinary and flagged cases: op, a, b, result, {ovf, unf, div by zero}
	// -----------------------------------------------------------------
	hfs_row_t rows [0:19] = '{
		'{2'h0, 32'h41100000, 32'h41100000, 32'h41200000, 3'h0},
		'{2'h0, 32'h431CAC40, 32'hC3100C40, 32'h42CA0000, 3'h0},
		'{2'h0, 32'h40800000, 32'h40800000, 32'h41100000, 3'h0},
		'{2'h0, 32'h41100000, 32'h3B100000, 32'h41100000, 3'h0},
		'{2'h0, 32'h41100000, 32'h40100001, 32'h41110000, 3'h0},
		'{2'h0, 32'h00000000, 32'h41100000, 32'h41100000, 3'h0},
		'{2'h1, 32'h41100000, 32'h41100000, 32'h00000000, 3'h0},
		'{2'h1, 32'h41100000, 32'h40800000, 32'h40800000, 3'h0},
		'{2'h1, 32'h41100000, 32'hC1100000, 32'h41200000, 3'h0},
		'{2'h2, 32'h41200000, 32'h41300000, 32'h41600000, 3'h0},
		'{2'h2, 32'h40800000, 32'h40800000, 32'h40400000, 3'h0},
		'{2'h2, 32'hC1200000, 32'h41300000, 32'hC1600000, 3'h0},
		'{2'h3, 32'h41600000, 32'h41200000, 32'h41300000, 3'h0},
		'{2'h3, 32'h41100000, 32'h41200000, 32'h40800000, 3'h0},
		'{2'h3, 32'h41100000, 32'h00000000, 32'h00000000, 3'h1},
		'{2'h2, 32'h7F100000, 32'h7F100000, 32'h00000000, 3'h4},
		'{2'h2, 32'h01100000, 32'h01100000, 32'h00000000, 3'h2},
		'{2'h0, 32'h7F800000, 32'h7F800000, 32'h00000000, 3'h4},
		'{2'h0, 32'h00100000, 32'h00100000, 32'h00200000, 3'h0},
		'{2'h1, 32'h41100001, 32'h41100000, 32'h3C100000, 3'h0}};

	hfs_datapath DUT (.mclk(mclk), .rst(rst), .start(start), .op(op), .a_hi(a_hi),
		.a_lo(a_lo), .b_hi(b_hi), .b_lo(b_lo), .busy(busy), .done(done), .r_hi(r_hi),
		.r_lo(r_lo), .exp_ovf(exp_ovf), .exp_unf(exp_unf), .div_zero(div_zero));

	// free-running 40 MHz clock
	initial
	begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end

	// hang guard: far above the few hundred cycles the tests need
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			close_out();
		end
	end

	task close_out;
		if (mismatches == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// request is held until the taking edge, then dropped
	task go(input hfs_row_t w);
		op = w.op;
		{a_hi, a_lo} = w.a;
		{b_hi, b_lo} = w.b;
		start = 1'h1;
		@(posedge mclk);
		#1 start = 1'h0;
	endtask

	// returns just after the edge that raised done, so the next go is back-to-back
	task wait_done;
		n = 0;
		while (done !== 1'h1 && n < 200)
		begin
			@(posedge mclk);
			#1 n++;
		end
		check("done", {31'h0, done}, 32'h1);
	endtask

	task check_idle;
		check("result", {r_hi, r_lo}, 32'h0);
		check("status", {27'h0, busy, done, exp_ovf, exp_unf, div_zero}, 32'h0);
	endtask

	// ordering seen through the top: a subtraction takes its sign from the larger operand
	task cmpc(input logic [31:0] a, input logic [31:0] b, input logic [31:0] exp);
		go({2'h1, a, b, 32'h0, 3'h0});
		wait_done();
		check("order", {r_hi, r_lo}, exp);
	endtask

	initial
	begin
		{start, op, a_hi, a_lo, b_hi, b_lo} = '0;
		rst = 1'h1;
		repeat (12) @(posedge mclk);
		#1 check_idle();
		rst = 1'h0;
		check_idle();
		// table of operations, flagged ones included, each started in the done cycle of the last
		foreach (rows[i])
		begin
			go(rows[i]);
			check("busy", {31'h0, busy}, 32'h1);
			wait_done();
			check("result", {r_hi, r_lo}, rows[i].r);
			check("flags", {29'h0, exp_ovf, exp_unf, div_zero}, {29'h0, rows[i].flg});
		end
		// a start while busy must be ignored, and done pulses only once
		@(posedge mclk);
		#1 go(rows[9]);
		@(posedge mclk);
		#1 go(rows[0]);
		wait_done();
		check("ignored start", {r_hi, r_lo}, 32'h41600000);
		n = 0;
		repeat (60)
		begin
			@(posedge mclk);
			#1 n += done;
		end
		check("extra done", n, 32'h0);
		// reset in mid-operation clears everything, then work resumes
		go(rows[2]);
		rst = 1'h1;
		#2 check_idle();
		@(posedge mclk);
		#1 rst = 1'h0;
		go(rows[1]);
		wait_done();
		check("after reset", {r_hi, r_lo}, 32'h42CA0000);
		// ordering: exponent decides first, mantissa only on a tie
		cmpc(32'h41100000, 32'h40FFFFFF, 32'h3C100000);
		cmpc(32'h40FFFFFF, 32'h41100000, 32'hBC100000);
		cmpc(32'h41200000, 32'h411FFFFF, 32'h3C100000);
		cmpc(32'h411FFFFF, 32'h411FFFFF, 32'h00000000);
		close_out();
	end
endmodule // hfs_datapath_tb_top
